// >>> rtl/bgdc_ctrl.sv
// Gate-drive control: power states, PWM decode, pulse shaping, dead time, zero-cross.
// Assumes inputs synchronous to sys_clk; three-level pins arrive as two comparator bits.
`timescale 1ns/1ps
module bgdc_ctrl #(
  parameter int FULL_START = bgdc_pkg::FULL_START_CYC,
  parameter int PART_START = bgdc_pkg::PART_START_CYC
) (
  input  wire logic                       sys_clk,
  input  wire logic                       sys_rst,
  input  wire logic                       clk_en,
  input  wire logic                       drive_enable_n,
  input  wire logic                       supply_undervoltage_lock,
  input  wire logic [1:0]                 pwm_level,
  input  wire logic [1:0]                 zero_cross_mode_sel,
  input  wire logic                       switch_node_sense,
  input  wire logic [bgdc_pkg::TRIM_W-1:0] trim_fuse,
  output bgdc_pkg::bgdc_gate_t            gate_cmd,
  output logic                            power_ready,
  output logic [bgdc_pkg::TRIM_W-1:0]     trim_value
);
  import bgdc_pkg::*;

  function automatic bgdc_lvl_t dec3(input logic [1:0] c);
    // c[1]: above upper threshold, c[0]: above lower threshold
    if (c[1]) dec3 = BGDC_LVL_HIGH;
    else if (c[0]) dec3 = BGDC_LVL_MID;
    else dec3 = BGDC_LVL_LOW;
  endfunction

  logic [1:0]       pwm_s1_q, pwm_s2_q, mode_s1_q, mode_s2_q;
  logic             zc_s1_q, zc_s2_q;
  bgdc_pwr_t        pwr_q, pwr_d;
  logic [CNT_W-1:0] st_cnt_q;
  bgdc_lvl_t        pwm_f_q, pwm_prev_q;
  logic [3:0]       gl_cnt_q;
  logic [3:0]       on_cnt_q;
  logic [7:0]       mid_cnt_q;
  logic [4:0]       blank_q;
  logic [1:0]       dead_q;
  logic             hs_req_q, zc_arm_q, zc_hold_q;
  bgdc_gate_t       gate_q;
  logic             rdy_q;
  logic [TRIM_W-1:0] trim_q;

  // Synchronisers
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_s1_q  <= 2'h0;
      pwm_s2_q  <= 2'h0;
      mode_s1_q <= 2'h1;
      mode_s2_q <= 2'h1;
      zc_s1_q   <= 1'b0;
      zc_s2_q   <= 1'b0;
    end else if (clk_en) begin
      pwm_s1_q  <= pwm_level;
      pwm_s2_q  <= pwm_s1_q;
      mode_s1_q <= zero_cross_mode_sel;
      mode_s2_q <= mode_s1_q;
      zc_s1_q   <= switch_node_sense;
      zc_s2_q   <= zc_s1_q;
    end
  end

  wire bgdc_lvl_t pwm_raw  = dec3(pwm_s2_q);
  wire bgdc_lvl_t mode_lvl = dec3(mode_s2_q);
  wire            zc_seen  = zc_s2_q;

  // Power-state sequencing
  wire supply_ok  = !supply_undervoltage_lock;
  wire enable_on  = drive_enable_n;
  wire cnt_done   = (st_cnt_q == '0);
  wire run        = (pwr_q == BGDC_PWR_RUN);

  always_comb begin
    pwr_d = pwr_q;
    case (pwr_q)
      BGDC_PWR_FULL: if (supply_ok) pwr_d = BGDC_PWR_PART;
      BGDC_PWR_PART: if (!supply_ok) pwr_d = BGDC_PWR_FULL;
                     else if (enable_on && cnt_done) pwr_d = BGDC_PWR_WAIT;
      BGDC_PWR_WAIT: if (!supply_ok) pwr_d = BGDC_PWR_FULL;
                     else if (!enable_on) pwr_d = BGDC_PWR_PART;
                     else if (cnt_done) pwr_d = BGDC_PWR_RUN;
      BGDC_PWR_RUN:  if (!supply_ok) pwr_d = BGDC_PWR_FULL;
                     else if (!enable_on) pwr_d = BGDC_PWR_PART;
      default:       pwr_d = BGDC_PWR_FULL;
    endcase
  end

  wire [CNT_W-1:0] full_ld = CNT_W'(FULL_START - PART_START);
  wire [CNT_W-1:0] part_ld = CNT_W'(PART_START);

  // Full start spends its extra time in PART, then the partial delay in WAIT
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwr_q    <= BGDC_PWR_FULL;
      st_cnt_q <= '0;
      trim_q   <= '0;
      rdy_q    <= 1'b0;
    end else if (clk_en) begin
      pwr_q <= pwr_d;
      if (pwr_q == BGDC_PWR_FULL)
        st_cnt_q <= full_ld;
      else if (pwr_d == BGDC_PWR_WAIT && pwr_q != BGDC_PWR_WAIT)
        st_cnt_q <= part_ld;
      else if (!cnt_done)
        st_cnt_q <= st_cnt_q - 1'b1;
      if (pwr_q == BGDC_PWR_PART)
        trim_q <= trim_fuse;
      rdy_q <= (pwr_d == BGDC_PWR_RUN);
    end
  end

  // Glitch filter: a level must hold GLITCH_CYC cycles to be accepted
  wire glitch_ok = ({1'b0, gl_cnt_q} + 5'h2 >= 5'(GLITCH_CYC));
  wire min_on_ok = (on_cnt_q >= 4'(MIN_ON_CYC - 1));

  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_prev_q <= BGDC_LVL_LOW;
      gl_cnt_q   <= '0;
      pwm_f_q    <= BGDC_LVL_LOW;
      on_cnt_q   <= '0;
      hs_req_q   <= 1'b0;
      mid_cnt_q  <= '0;
    end else if (clk_en) begin
      pwm_prev_q <= pwm_raw;
      if (pwm_raw != pwm_prev_q)
        gl_cnt_q <= '0;
      else if (!glitch_ok)
        gl_cnt_q <= gl_cnt_q + 1'b1;
      if (glitch_ok && pwm_raw == pwm_prev_q)
        pwm_f_q <= pwm_raw;
      if (!run)
        hs_req_q <= 1'b0;
      else if (pwm_f_q == BGDC_LVL_HIGH)
        hs_req_q <= 1'b1;
      else if (min_on_ok || !hs_req_q)
        hs_req_q <= 1'b0;
      if (!gate_q.high_side_gate)
        on_cnt_q <= '0;
      else if (!min_on_ok)
        on_cnt_q <= on_cnt_q + 1'b1;
      if (pwm_f_q != BGDC_LVL_MID)
        mid_cnt_q <= '0;
      else if (mid_cnt_q != 8'(HOLDOFF_CYC))
        mid_cnt_q <= mid_cnt_q + 1'b1;
    end
  end

  wire mid_hold   = (mid_cnt_q == 8'(HOLDOFF_CYC));
  // Low-side wish per decoded mode
  wire zc_mode    = (mode_lvl == BGDC_LVL_HIGH && pwm_f_q == BGDC_LVL_MID) ||
                    (mode_lvl == BGDC_LVL_MID  && pwm_f_q == BGDC_LVL_LOW);
  wire ls_plain   = (pwm_f_q == BGDC_LVL_LOW);
  wire ls_zc_req  = zc_mode && (zc_arm_q || blank_q != '0 || !zc_hold_q);
  // Mode low or mid with PWM mid: both off
  wire ls_want    = run && !hs_req_q && (zc_mode ? ls_zc_req : (ls_plain && mode_lvl != BGDC_LVL_MID));
  wire hs_want    = run && hs_req_q && !mid_hold;
  wire both_off   = !gate_q.high_side_gate && !gate_q.low_side_gate;
  wire dead_done  = (dead_q == 2'(DEAD_CYC));

  // Zero-cross: blanking then release on sensed zero current
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      blank_q   <= '0;
      zc_arm_q  <= 1'b0;
      zc_hold_q <= 1'b0;
      dead_q    <= '0;
      gate_q    <= '0;
    end else if (clk_en) begin
      if (!zc_mode) begin
        zc_hold_q <= 1'b0;
        zc_arm_q  <= 1'b0;
        blank_q   <= '0;
      end else if (!zc_hold_q && gate_q.low_side_gate) begin
        zc_hold_q <= 1'b1;
        zc_arm_q  <= 1'b1;
        blank_q   <= 5'(BLANK_CYC);
      end else if (blank_q != '0)
        blank_q <= blank_q - 1'b1;
      else if (zc_seen)
        zc_arm_q <= 1'b0;
      if (!run)
        gate_q <= '0;
      else if ((gate_q.high_side_gate && !hs_want) || (gate_q.low_side_gate && !ls_want))
        gate_q <= '0;
      else if (both_off && !dead_done && (hs_want || ls_want))
        dead_q <= dead_q + 1'b1;
      else if (both_off && dead_done) begin
        gate_q.high_side_gate <= hs_want;
        gate_q.low_side_gate  <= ls_want && !hs_want;
      end
      if (!both_off || !(hs_want || ls_want))
        dead_q <= '0;
    end
  end

  assign gate_cmd    = gate_q;
  assign power_ready = rdy_q;
  assign trim_value  = trim_q;

  property p_no_overlap;
    @(posedge sys_clk) disable iff (sys_rst) !(gate_q.high_side_gate && gate_q.low_side_gate);
  endproperty
  a_no_overlap: assert property (p_no_overlap) else $error("Gates on together");

  property p_off_when_down;
    @(posedge sys_clk) disable iff (sys_rst) clk_en && !run |=> !gate_q.high_side_gate && !gate_q.low_side_gate;
  endproperty
  a_off_when_down: assert property (p_off_when_down) else $error("Gate on while not running");

  property p_supply_undervoltage_lock_full;
    @(posedge sys_clk) disable iff (sys_rst) clk_en && supply_undervoltage_lock |=> pwr_q == BGDC_PWR_FULL;
  endproperty
  a_supply_undervoltage_lock_full: assert property (p_supply_undervoltage_lock_full) else $error("No full shutdown");

  property p_part;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && supply_ok && !drive_enable_n && run |=> pwr_q == BGDC_PWR_PART;
  endproperty
  a_part: assert property (p_part) else $error("No partial shutdown");

  property p_ready;
    @(posedge sys_clk) disable iff (sys_rst) rdy_q |-> run;
  endproperty
  a_ready: assert property (p_ready) else $error("Ready before run");

  property p_holdoff;
    @(posedge sys_clk) disable iff (sys_rst) mid_hold |=> !gate_q.high_side_gate;
  endproperty
  a_holdoff: assert property (p_holdoff) else $error("High gate on after hold-off");

  property p_mid_off;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && mode_lvl != BGDC_LVL_HIGH && pwm_f_q == BGDC_LVL_MID && !hs_req_q |=> !gate_q.low_side_gate;
  endproperty
  a_mid_off: assert property (p_mid_off) else $error("Low gate on in mid");

  property p_trim;
    @(posedge sys_clk) disable iff (sys_rst) clk_en && pwr_q == BGDC_PWR_PART |=> trim_q == $past(trim_fuse);
  endproperty
  a_trim: assert property (p_trim) else $error("Trim not loaded");

  sequence s_hs_short;
    gate_q.high_side_gate && !min_on_ok && run;
  endsequence
  property p_min_on;
    @(posedge sys_clk) disable iff (sys_rst) s_hs_short |=> gate_q.high_side_gate;
  endproperty
  a_min_on: assert property (p_min_on) else $error("High pulse cut short");

  property p_dead_high;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(gate_q.high_side_gate) |-> $past(both_off, 1) && $past(both_off, 2) && $past(both_off, 3);
  endproperty
  a_dead_high: assert property (p_dead_high) else $error("No dead time before high gate");

  property p_dead_low;
    @(posedge sys_clk) disable iff (sys_rst)
      $rose(gate_q.low_side_gate) |-> $past(both_off, 1) && $past(both_off, 2) && $past(both_off, 3);
  endproperty
  a_dead_low: assert property (p_dead_low) else $error("No dead time before low gate");

  property p_zc_blank;
    @(posedge sys_clk) disable iff (sys_rst)
      gate_q.low_side_gate && zc_mode && blank_q != '0 && run && !hs_req_q |=> gate_q.low_side_gate;
  endproperty
  a_zc_blank: assert property (p_zc_blank) else $error("Low gate off during blanking");

  // Zero current seen after blanking, mode kept for one more cycle
  sequence s_zc_seen;
    gate_q.low_side_gate && zc_mode && zc_hold_q && blank_q == '0 && zc_seen && clk_en ##1 zc_mode && clk_en;
  endsequence
  property p_zc_release;
    @(posedge sys_clk) disable iff (sys_rst) s_zc_seen |=> !gate_q.low_side_gate;
  endproperty
  a_zc_release: assert property (p_zc_release) else $error("Low gate kept after zero current");

  property p_plain_low;
    @(posedge sys_clk) disable iff (sys_rst)
      gate_q.low_side_gate && mode_lvl == BGDC_LVL_LOW && pwm_f_q == BGDC_LVL_LOW && run && !hs_req_q
      |=> gate_q.low_side_gate;
  endproperty
  a_plain_low: assert property (p_plain_low) else $error("Low gate cut in plain mode");

  property p_low_mid_off;
    @(posedge sys_clk) disable iff (sys_rst)
      clk_en && mode_lvl == BGDC_LVL_LOW && pwm_f_q == BGDC_LVL_MID && !hs_req_q |=> gate_q == '0;
  endproperty
  a_low_mid_off: assert property (p_low_mid_off) else $error("Gate on with mode low and PWM mid");

  sequence s_pwm_high;
    (run && pwm_f_q == BGDC_LVL_HIGH && clk_en) [*6];
  endsequence
  property p_hs_follow;
    @(posedge sys_clk) disable iff (sys_rst) s_pwm_high |-> gate_q.high_side_gate;
  endproperty
  a_hs_follow: assert property (p_hs_follow) else $error("High gate not following PWM");

  sequence s_two_en;
    !sys_rst && clk_en ##1 clk_en;
  endsequence
  property p_sync;
    @(posedge sys_clk) disable iff (sys_rst)
      s_two_en |=> pwm_s2_q == $past(pwm_level, 2) && mode_s2_q == $past(zero_cross_mode_sel, 2)
      && zc_s2_q == $past(switch_node_sense, 2);
  endproperty
  a_sync: assert property (p_sync) else $error("Input not passed through two flops");
endmodule

// >>> rtl/bgdc_pkg.sv
// Constants, types and state encodings for the buck gate-drive control block.
// Assumes a single 250 MHz clock; all inputs are synchronous to it.
// Behaviour
// - Switching only when enable asserted and supply good; else gates off.
// - Undervoltage forces full shutdown, gates low; 40 us to ready after recovery.
// - Supply good, enable low: partial shutdown, gates low; 30 us to ready.
// - Enabled and good: gates follow decoded PWM and zero-cross mode.
// - Ready output held low until start-up delay completes.
// - Trim and configuration loaded during partial shutdown before switching; only trim is latched here, mode pin is sampled every cycle.
// - Mode low: plain synchronous rectifier, no zero-current turn-off.
// - Mode high, PWM mid: high off, low on after delay, blanking, zero-current off.
// - Mode mid, PWM low: low on after delay, blanking, then zero-current off.
// - Mode pin decoded three-level; open reads as mid.
// - PWM decoded three-level: high, low, mid per mode pin.
// - Short high pulses stretched to 37 ns minimum.
// - Pulses narrower than 5 ns ignored, gates unchanged.
// - Mode low, PWM mid: both gates off at once.
// - High gate in phase with PWM, low gate its complement.
// - Non-overlap delay on both transitions; gates never on together.
// - High gate held low after PWM stays mid beyond hold-off time.
package bgdc_pkg;
  localparam int CLK_MHZ          = 250;
  localparam int FULL_START_US    = 40;
  localparam int PART_START_US    = 30;
  localparam int MIN_ON_NS        = 37;
  localparam int GLITCH_NS        = 5;
  localparam int FULL_START_CYC   = FULL_START_US * CLK_MHZ;
  localparam int PART_START_CYC   = PART_START_US * CLK_MHZ;
  localparam int MIN_ON_CYC       = (MIN_ON_NS * CLK_MHZ + 999) / 1000;
  localparam int GLITCH_CYC       = (GLITCH_NS * CLK_MHZ + 999) / 1000;
  localparam int DEAD_CYC         = 2;
  localparam int BLANK_CYC        = 16;
  localparam int HOLDOFF_CYC      = 32;
  localparam int CNT_W            = 16;
  localparam int TRIM_W           = 8;

  typedef enum logic [1:0] {
    BGDC_LVL_LOW  = 2'b00,
    BGDC_LVL_MID  = 2'b01,
    BGDC_LVL_HIGH = 2'b10
  } bgdc_lvl_t;

  typedef enum logic [1:0] {
    BGDC_PWR_FULL = 2'b00,
    BGDC_PWR_PART = 2'b01,
    BGDC_PWR_WAIT = 2'b10,
    BGDC_PWR_RUN  = 2'b11
  } bgdc_pwr_t;

  typedef struct packed {
    logic high_side_gate;
    logic low_side_gate;
  } bgdc_gate_t;
endpackage

// >>> sim/bgdc_pwm_model.sv
// Partner model: one phase of the multiphase controller plus the switch node.
// Assumes the bench picks the PWM level on cmd_lvl; the model turns it into comparator bits.
`timescale 1ns/1ps
module bgdc_pwm_model (
  input  wire logic                 sys_clk,
  input  wire logic                 sys_rst,
  input  wire bgdc_pkg::bgdc_lvl_t  cmd_lvl,
  input  wire bgdc_pkg::bgdc_gate_t gate_cmd,
  output logic [1:0]                pwm_level,
  output logic                      switch_node_sense
);
  import bgdc_pkg::*;
  logic [3:0] disch_q;
  // Short test pulses are commanded on purpose; normal periods stay long
  always_ff @(posedge sys_clk or posedge sys_rst) begin
    if (sys_rst) begin
      pwm_level <= 2'b01;
      disch_q   <= 4'h0;
    end else begin
      pwm_level <= (cmd_lvl == BGDC_LVL_HIGH) ? 2'b11 : ((cmd_lvl == BGDC_LVL_MID) ? 2'b01 : 2'b00);
      disch_q   <= !gate_cmd.low_side_gate ? 4'h0 : ((disch_q == 4'hf) ? disch_q : disch_q + 4'h1);
    end
  end
  // Inductor current falls to zero early, before blanking ends
  assign switch_node_sense = (disch_q >= 4'h3);
endmodule

// >>> sim/bgdc_ctrl_test.sv
// Self-checking bench for the gate-drive control block.
// Assumes shortened start-up counts; the partner model drives PWM and zero-current sense.
`timescale 1ns/1ps
module bgdc_ctrl_test;
  import bgdc_pkg::*;
  localparam int FULL_SIM = 40;
  localparam int PART_SIM = 30;
  typedef struct packed {
    bgdc_lvl_t  mode;
    bgdc_lvl_t  pwm;
    bgdc_gate_t fin;
    logic       low_seen;
    logic       zero_current_turnoff;
  } bgdc_row_t;
  logic       sys_clk, sys_rst, clk_en, drive_enable_n, supply_undervoltage_lock, switch_node_sense;
  logic [1:0] pwm_level, zero_cross_mode_sel;
  logic [7:0] trim_fuse, trim_value;
  logic       power_ready;
  bgdc_gate_t gate_cmd;
  bgdc_lvl_t  cmd_lvl;
  int         n_mismatch, n_compared, gl_cnt, gh_cnt, ov_cnt;
  bgdc_row_t  rows [9] = '{
    '{BGDC_LVL_LOW, BGDC_LVL_HIGH, 2'b10, 1'b0, 1'b0}, '{BGDC_LVL_LOW, BGDC_LVL_LOW, 2'b01, 1'b1, 1'b0},
    '{BGDC_LVL_LOW, BGDC_LVL_MID, 2'b00, 1'b0, 1'b0}, '{BGDC_LVL_HIGH, BGDC_LVL_HIGH, 2'b10, 1'b0, 1'b0},
    '{BGDC_LVL_HIGH, BGDC_LVL_LOW, 2'b01, 1'b1, 1'b0}, '{BGDC_LVL_HIGH, BGDC_LVL_MID, 2'b00, 1'b1, 1'b1},
    '{BGDC_LVL_MID, BGDC_LVL_HIGH, 2'b10, 1'b0, 1'b0}, '{BGDC_LVL_MID, BGDC_LVL_LOW, 2'b00, 1'b1, 1'b1},
    '{BGDC_LVL_MID, BGDC_LVL_MID, 2'b00, 1'b0, 1'b0}};

  bgdc_ctrl #(.FULL_START(FULL_SIM), .PART_START(PART_SIM)) bgdc_ctrl_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .clk_en(clk_en), .drive_enable_n(drive_enable_n),
    .supply_undervoltage_lock(supply_undervoltage_lock), .pwm_level(pwm_level),
    .zero_cross_mode_sel(zero_cross_mode_sel), .switch_node_sense(switch_node_sense),
    .trim_fuse(trim_fuse), .gate_cmd(gate_cmd), .power_ready(power_ready), .trim_value(trim_value));
  bgdc_pwm_model bgdc_pwm_model_inst (
    .sys_clk(sys_clk), .sys_rst(sys_rst), .cmd_lvl(cmd_lvl), .gate_cmd(gate_cmd),
    .pwm_level(pwm_level), .switch_node_sense(switch_node_sense));

  function automatic logic [1:0] enc(input bgdc_lvl_t l);
    return (l == BGDC_LVL_HIGH) ? 2'b11 : ((l == BGDC_LVL_MID) ? 2'b01 : 2'b00);
  endfunction
  task automatic print_verdict;
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask
  task automatic chk_gate(input string what, input bgdc_gate_t exp, input bgdc_gate_t got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_bit(input string what, input logic exp, input logic got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
    end
  endtask
  task automatic chk_trim(input string what, input logic [7:0] exp, input logic [7:0] got);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic step(input bgdc_lvl_t lvl, input int n);
    cmd_lvl <= lvl;
    repeat (n) @(posedge sys_clk);
  endtask
  // Bounded wait for ready; low before the earliest legal edge
  task automatic wait_ready(input string what, input int lo, input int hi);
    int t;
    t = 0;
    while (power_ready !== 1'b1 && t < hi) begin
      @(posedge sys_clk);
      t++;
    end
    chk_bit({what, " not early"}, 1'b1, logic'(t >= lo));
    chk_bit(what, 1'b1, power_ready);
    if (power_ready !== 1'b1) print_verdict();
  endtask

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(negedge sys_clk) begin
    gl_cnt += int'(gate_cmd.low_side_gate === 1'b1);
    gh_cnt += int'(gate_cmd.high_side_gate === 1'b1);
    ov_cnt += int'(gate_cmd === 2'b11);
  end
  initial begin
    #200us;
    n_mismatch++;
    $display("CHECK FAILED run time expected finish seen timeout");
    print_verdict();
  end

  initial begin
    {n_mismatch, n_compared, gl_cnt, gh_cnt, ov_cnt} = '0;
    sys_rst = 1'b1;
    clk_en = 1'b1;
    drive_enable_n = 1'b1;
    supply_undervoltage_lock = 1'b1;
    zero_cross_mode_sel = 2'b01;
    trim_fuse = 8'h5a;
    cmd_lvl = BGDC_LVL_HIGH;
    repeat (4) @(posedge sys_clk);
    sys_rst <= 1'b0;
    step(BGDC_LVL_HIGH, 20);
    chk_gate("gates supply bad", 2'b00, gate_cmd);
    chk_bit("ready supply bad", 1'b0, power_ready);
    supply_undervoltage_lock <= 1'b0;
    wait_ready("full start ready", FULL_SIM, FULL_SIM + 12);
    $display("test full_start done");
    foreach (rows[i]) begin
      zero_cross_mode_sel <= enc(rows[i].mode);
      step(BGDC_LVL_HIGH, 24);
      {gl_cnt, ov_cnt} = '0;
      step(rows[i].pwm, 60);
      chk_gate("row gates", rows[i].fin, gate_cmd);
      chk_bit("row low gate on", rows[i].low_seen, logic'(gl_cnt > 0));
      if (rows[i].zero_current_turnoff) chk_bit("row blanking", 1'b1, logic'(gl_cnt >= BLANK_CYC));
      chk_bit("row overlap", 1'b0, logic'(ov_cnt > 0));
    end
    $display("test logic_table done");
    zero_cross_mode_sel <= 2'b00;
    step(BGDC_LVL_LOW, 30);
    {gl_cnt, gh_cnt} = '0;
    step(BGDC_LVL_HIGH, 1);
    step(BGDC_LVL_LOW, 30);
    chk_bit("glitch high gate", 1'b1, logic'(gh_cnt == 0 && gl_cnt == 31));
    {gh_cnt, ov_cnt} = '0;
    step(BGDC_LVL_HIGH, 2);
    step(BGDC_LVL_LOW, 40);
    chk_bit("stretched width", 1'b1, logic'(gh_cnt >= MIN_ON_CYC));
    chk_bit("stretch overlap", 1'b0, logic'(ov_cnt > 0));
    $display("test pulse_shaping done");
    drive_enable_n <= 1'b0;
    step(BGDC_LVL_HIGH, 10);
    chk_gate("gates disabled", 2'b00, gate_cmd);
    chk_bit("ready disabled", 1'b0, power_ready);
    trim_fuse <= 8'ha5;
    step(BGDC_LVL_HIGH, 5);
    chk_trim("trim in sleep", 8'ha5, trim_value);
    drive_enable_n <= 1'b1;
    wait_ready("partial start ready", PART_SIM, PART_SIM + 8);
    step(BGDC_LVL_HIGH, 20);
    chk_gate("gates re-enabled", 2'b10, gate_cmd);
    supply_undervoltage_lock <= 1'b1;
    step(BGDC_LVL_HIGH, 8);
    chk_gate("gates lockout", 2'b00, gate_cmd);
    chk_bit("ready lockout", 1'b0, power_ready);
    $display("test enable_paths done");
    print_verdict();
  end
endmodule
